// >>> pin_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
	// clock
	input  wire logic clk_sys,
	// requested pin levels
	input  wire logic ev_lvl,
	input  wire logic dir_lvl,
	// pins toward the timer
	output logic      event_count_pin,
	output logic      dir_select_pin
);
	// pin functions assumed enabled, own pin irq masked
	always_ff @(posedge clk_sys) begin
		event_count_pin <= ev_lvl;
		dir_select_pin  <= dir_lvl;
	end
endmodule
`default_nettype wire

// >>> updown_reload_timer8.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module updown_reload_timer8 (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// register port
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// pins
	input  wire logic       event_count_pin,
	input  wire logic       dir_select_pin,
	// interrupt request
	output logic            timer_irq
);
	import updown_reload_timer8_pkg::*;

	logic [7:0]               timer_mode_control_q;
	logic [7:0]               counter_value_q;
	logic [7:0]               reload_value_q;
	logic                     timer_irq_flag_q;
	logic                     timer_irq_enable_q;
	logic                     event_edge_select_q;
	logic [PRESCALE_BITS-1:0] prescale_q;
	logic [PRESCALE_BITS-1:0] prescale_d;
	logic                     event_prev_q;
	logic                     count_en;
	logic                     tap_en;
	logic                     edge_en;
	logic                     count_down;
	logic                     wrap;
	logic                     reload_wr;
	logic [2:0]               clksel;
	logic [CLKSEL_EXTERNAL:0] tap_hit;
	logic [7:0]               counter_d;

	assign clksel    = timer_mode_control_q[MODE_CLKSEL_MSB:0];
	assign reload_wr = reg_wr && (reg_addr == ADDR_COUNT_RELOAD);

	// free-running prescaler
	assign prescale_d = prescale_q + {{(PRESCALE_BITS-1){1'b0}}, 1'b1};
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prescale_q <= '0;
		end else begin
			prescale_q <= prescale_d;
		end
	end

	// tap pulse: one cycle when the low tap bits roll over
	for (genvar t = 0; t < CLKSEL_EXTERNAL; t++) begin : g_tap
		assign tap_hit[t] = prescale_q[TAP_LOG2[t]-1] && !prescale_d[TAP_LOG2[t]-1];
	end
	// the event code has no tap
	assign tap_hit[CLKSEL_EXTERNAL] = 1'b0;

	assign tap_en = (clksel != CLKSEL_EXTERNAL) && tap_hit[clksel];

	// event pin edge detect, pin taken as synchronous
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			event_prev_q <= 1'b0;
		end else begin
			event_prev_q <= event_count_pin;
		end
	end

	// edge select 1 rising, 0 falling
	assign edge_en = (clksel == CLKSEL_EXTERNAL) &&
		(event_edge_select_q ? (event_count_pin && !event_prev_q)
		                     : (!event_count_pin && event_prev_q));

	assign count_en = tap_en || edge_en;

	assign count_down = timer_mode_control_q[MODE_HWDIR_BIT] ? dir_select_pin
	                                                         : timer_mode_control_q[MODE_SWDIR_BIT];

	assign wrap = count_en && (count_down ? (counter_value_q == COUNT_MIN)
	                                      : (counter_value_q == COUNT_MAX));

	// counter next value
	always_comb begin
		counter_d = counter_value_q;
		if (reload_wr) begin
			counter_d = reg_wdata;
		end else if (wrap && timer_mode_control_q[MODE_AUTORELOAD_BIT]) begin
			counter_d = reload_value_q;
		end else if (count_en) begin
			counter_d = count_down ? counter_value_q - COUNT_ONE
			                       : counter_value_q + COUNT_ONE;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			counter_value_q <= COUNT_RESET;
		end else begin
			counter_value_q <= counter_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reload_value_q <= RELOAD_RESET;
		end else if (reload_wr) begin
			reload_value_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_mode_control_q <= MODE_RESET;
		end else if (reg_wr && (reg_addr == ADDR_MODE_CONTROL)) begin
			timer_mode_control_q <= (reg_wdata & MODE_WRITE_MASK) | MODE_FIXED_ONES;
		end
	end

	// irq control: enable and edge select written, flag cleared by writing 0
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_irq_enable_q  <= 1'b0;
			event_edge_select_q <= 1'b0;
		end else if (reg_wr && (reg_addr == ADDR_IRQ_CONTROL)) begin
			timer_irq_enable_q  <= reg_wdata[IRQ_ENABLE_BIT];
			event_edge_select_q <= reg_wdata[IRQ_EDGE_BIT];
		end
	end

	// set wins over a simultaneous clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_irq_flag_q <= 1'b0;
		end else if (wrap) begin
			timer_irq_flag_q <= 1'b1;
		end else if (reg_wr && (reg_addr == ADDR_IRQ_CONTROL) && !reg_wdata[IRQ_FLAG_BIT]) begin
			timer_irq_flag_q <= 1'b0;
		end
	end

	assign timer_irq = timer_irq_flag_q && timer_irq_enable_q;

	// read data one cycle after the strobe; counter read has no side effect
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_MODE_CONTROL: reg_rdata <= timer_mode_control_q;
				ADDR_COUNT_RELOAD: reg_rdata <= counter_value_q;
				ADDR_IRQ_CONTROL:  reg_rdata <= {5'h00, event_edge_select_q,
				                                 timer_irq_enable_q, timer_irq_flag_q};
				default:           reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// assertions
	sequence s_mode_write;
		reg_wr && (reg_addr == ADDR_MODE_CONTROL);
	endsequence

	sequence s_irq_write;
		reg_wr && (reg_addr == ADDR_IRQ_CONTROL);
	endsequence

	sequence s_flag_clear;
		reg_wr && (reg_addr == ADDR_IRQ_CONTROL) && !reg_wdata[IRQ_FLAG_BIT] && !wrap;
	endsequence

	sequence s_up_step;
		count_en && !wrap && !reload_wr && !count_down;
	endsequence

	sequence s_down_step;
		count_en && !wrap && !reload_wr && count_down;
	endsequence

	sequence s_counter_read;
		reg_rd && (reg_addr == ADDR_COUNT_RELOAD);
	endsequence

	sequence s_mode_read;
		reg_rd && (reg_addr == ADDR_MODE_CONTROL);
	endsequence

	sequence s_irq_read;
		reg_rd && (reg_addr == ADDR_IRQ_CONTROL);
	endsequence

	a_step_down: assert property (@(posedge clk_sys) disable iff (rst)
		s_down_step |=> counter_value_q == $past(counter_value_q) - COUNT_ONE)
		else $error("down step not one");

	a_step_up_seq: assert property (@(posedge clk_sys) disable iff (rst)
		s_up_step |=> counter_value_q == $past(counter_value_q) + COUNT_ONE)
		else $error("up step sequence not one");

	a_sw_direction: assert property (@(posedge clk_sys) disable iff (rst)
		!timer_mode_control_q[MODE_HWDIR_BIT] |-> count_down == timer_mode_control_q[MODE_SWDIR_BIT])
		else $error("software bit does not steer direction");

	a_hw_up: assert property (@(posedge clk_sys) disable iff (rst)
		timer_mode_control_q[MODE_HWDIR_BIT] && !dir_select_pin |-> !count_down)
		else $error("low pin does not count up");

	a_mode_write: assert property (@(posedge clk_sys) disable iff (rst)
		s_mode_write
		|=> timer_mode_control_q == (($past(reg_wdata) & MODE_WRITE_MASK) | MODE_FIXED_ONES))
		else $error("mode write not stored");

	a_mode_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!(reg_wr && (reg_addr == ADDR_MODE_CONTROL)) |=> $stable(timer_mode_control_q))
		else $error("mode changed without write");

	a_irq_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
		s_irq_write |=> timer_irq_enable_q == $past(reg_wdata[IRQ_ENABLE_BIT])
		&& event_edge_select_q == $past(reg_wdata[IRQ_EDGE_BIT]))
		else $error("irq control write not stored");

	a_irq_ctrl_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!(reg_wr && (reg_addr == ADDR_IRQ_CONTROL))
		|=> $stable(timer_irq_enable_q) && $stable(event_edge_select_q))
		else $error("irq control changed without write");

	a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
		s_flag_clear |=> !timer_irq_flag_q)
		else $error("flag not cleared");

	a_flag_keep: assert property (@(posedge clk_sys) disable iff (rst)
		s_irq_write ##0 (reg_wdata[IRQ_FLAG_BIT] && timer_irq_flag_q) |=> timer_irq_flag_q)
		else $error("flag lost on keep write");

	a_flag_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!wrap && !(reg_wr && (reg_addr == ADDR_IRQ_CONTROL) && !reg_wdata[IRQ_FLAG_BIT])
		|=> $stable(timer_irq_flag_q))
		else $error("flag changed without cause");

	a_wrap_flag_up: assert property (@(posedge clk_sys) disable iff (rst)
		count_en && !count_down && (counter_value_q == COUNT_MAX) |=> timer_irq_flag_q)
		else $error("overflow did not set flag");

	a_wrap_flag_down: assert property (@(posedge clk_sys) disable iff (rst)
		count_en && count_down && (counter_value_q == COUNT_MIN) |=> timer_irq_flag_q)
		else $error("underflow did not set flag");

	a_overflow_irq: assert property (@(posedge clk_sys) disable iff (rst)
		wrap && timer_irq_enable_q && !(reg_wr && (reg_addr == ADDR_IRQ_CONTROL)) |=> timer_irq)
		else $error("enabled wrap raised no irq");

	a_reload_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!reload_wr |=> $stable(reload_value_q))
		else $error("reload changed without write");

	a_interval_load: assert property (@(posedge clk_sys) disable iff (rst)
		reload_wr && !timer_mode_control_q[MODE_AUTORELOAD_BIT] |=> counter_value_q == $past(reg_wdata))
		else $error("interval write did not load counter");

	a_auto_restart: assert property (@(posedge clk_sys) disable iff (rst)
		reload_wr && timer_mode_control_q[MODE_AUTORELOAD_BIT] |=> counter_value_q == $past(reg_wdata))
		else $error("auto-reload write did not restart counter");

	a_auto_up_wrap: assert property (@(posedge clk_sys) disable iff (rst)
		count_en && !count_down && (counter_value_q == COUNT_MAX) && !reload_wr
		&& timer_mode_control_q[MODE_AUTORELOAD_BIT] |=> counter_value_q == $past(reload_value_q))
		else $error("overflow did not reload");

	a_auto_down_wrap: assert property (@(posedge clk_sys) disable iff (rst)
		count_en && count_down && (counter_value_q == COUNT_MIN) && !reload_wr
		&& timer_mode_control_q[MODE_AUTORELOAD_BIT] |=> counter_value_q == $past(reload_value_q))
		else $error("underflow did not reload");

	a_read_counter: assert property (@(posedge clk_sys) disable iff (rst)
		s_counter_read |=> reg_rdata == $past(counter_value_q))
		else $error("counter read wrong");

	a_read_mode: assert property (@(posedge clk_sys) disable iff (rst)
		s_mode_read |=> reg_rdata == $past(timer_mode_control_q))
		else $error("mode read wrong");

	a_read_irq: assert property (@(posedge clk_sys) disable iff (rst)
		s_irq_read |=> reg_rdata == {5'h00, $past(event_edge_select_q),
		$past(timer_irq_enable_q), $past(timer_irq_flag_q)})
		else $error("irq control read wrong");

	a_read_unmapped: assert property (@(posedge clk_sys) disable iff (rst)
		reg_rd && (reg_addr != ADDR_MODE_CONTROL) && (reg_addr != ADDR_COUNT_RELOAD)
		&& (reg_addr != ADDR_IRQ_CONTROL) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero when idle");

	a_tap_single: assert property (@(posedge clk_sys) disable iff (rst)
		tap_en |=> !tap_en)
		else $error("tap enable longer than one cycle");

	a_ext_no_tap: assert property (@(posedge clk_sys) disable iff (rst)
		clksel == CLKSEL_EXTERNAL |-> !tap_en)
		else $error("tap counted in event mode");

	a_tap_no_edge: assert property (@(posedge clk_sys) disable iff (rst)
		clksel != CLKSEL_EXTERNAL |-> !edge_en)
		else $error("pin edge counted in tap mode");

	a_ext_fall: assert property (@(posedge clk_sys) disable iff (rst)
		clksel == CLKSEL_EXTERNAL && !event_edge_select_q && $fell(event_count_pin) |-> count_en)
		else $error("selected falling edge not counted");

	a_ext_wrong_edge: assert property (@(posedge clk_sys) disable iff (rst)
		clksel == CLKSEL_EXTERNAL && event_edge_select_q && !$rose(event_count_pin) |-> !edge_en)
		else $error("unselected edge counted");

	a_prescale_run: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> prescale_q == $past(prescale_q) + {{(PRESCALE_BITS-1){1'b0}}, 1'b1})
		else $error("prescaler not free running");

	a_mode_fixed_ones: assert property (@(posedge clk_sys) disable iff (rst)
		(timer_mode_control_q & MODE_FIXED_ONES) == MODE_FIXED_ONES)
		else $error("mode fixed bits not one");

	a_irq_gating: assert property (@(posedge clk_sys) disable iff (rst)
		timer_irq == (timer_irq_flag_q && timer_irq_enable_q && 1'b1) || !timer_irq_enable_q && !timer_irq)
		else $error("irq output not gated by enable");

	a_wrap_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
		wrap |=> timer_irq_flag_q)
		else $error("wrap did not set flag");

	a_interval_wrap_up: assert property (@(posedge clk_sys) disable iff (rst)
		wrap && !count_down && !reload_wr && !timer_mode_control_q[MODE_AUTORELOAD_BIT]
		|=> counter_value_q == COUNT_MIN)
		else $error("interval up wrap not to zero");

	a_interval_wrap_down: assert property (@(posedge clk_sys) disable iff (rst)
		wrap && count_down && !reload_wr && !timer_mode_control_q[MODE_AUTORELOAD_BIT]
		|=> counter_value_q == COUNT_MAX)
		else $error("interval down wrap not to ff");

	a_autoreload_load: assert property (@(posedge clk_sys) disable iff (rst)
		wrap && !reload_wr && timer_mode_control_q[MODE_AUTORELOAD_BIT]
		|=> counter_value_q == $past(reload_value_q))
		else $error("auto-reload value not loaded");

	a_reload_write: assert property (@(posedge clk_sys) disable iff (rst)
		reload_wr |=> counter_value_q == $past(reg_wdata) && reload_value_q == $past(reg_wdata))
		else $error("reload write did not load counter");

	a_step_one: assert property (@(posedge clk_sys) disable iff (rst)
		count_en && !wrap && !reload_wr && !count_down |=> counter_value_q == $past(counter_value_q) + COUNT_ONE)
		else $error("up step not one");

	a_hold_idle: assert property (@(posedge clk_sys) disable iff (rst)
		!count_en && !reload_wr |=> $stable(counter_value_q))
		else $error("counter moved without enable");

	a_hw_direction: assert property (@(posedge clk_sys) disable iff (rst)
		timer_mode_control_q[MODE_HWDIR_BIT] |-> count_down == dir_select_pin)
		else $error("pin does not steer direction");

	a_ext_edge: assert property (@(posedge clk_sys) disable iff (rst)
		clksel == CLKSEL_EXTERNAL && event_edge_select_q && $rose(event_count_pin) |-> count_en)
		else $error("selected edge not counted");
endmodule
`default_nettype wire

// >>> updown_reload_timer8_pkg.sv
package updown_reload_timer8_pkg;
	// register indices (one byte each)
	localparam logic [1:0] ADDR_MODE_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_COUNT_RELOAD = 2'h1;
	localparam logic [1:0] ADDR_IRQ_CONTROL  = 2'h2;
	// mode control fields
	localparam int         MODE_AUTORELOAD_BIT = 7;
	localparam int         MODE_HWDIR_BIT      = 6;
	localparam int         MODE_SWDIR_BIT      = 5;
	localparam int         MODE_CLKSEL_MSB     = 2;
	localparam logic [7:0] MODE_WRITE_MASK     = 8'he7;
	localparam logic [7:0] MODE_FIXED_ONES     = 8'h18;
	localparam logic [7:0] MODE_RESET          = 8'h18;
	localparam logic [2:0] CLKSEL_EXTERNAL     = 3'h7;
	// irq control fields: flag, enable, edge select
	localparam int         IRQ_FLAG_BIT        = 0;
	localparam int         IRQ_ENABLE_BIT      = 1;
	localparam int         IRQ_EDGE_BIT        = 2;
	localparam logic [7:0] COUNT_RESET         = 8'h00;
	localparam logic [7:0] RELOAD_RESET        = 8'h00;
	localparam logic [7:0] COUNT_MAX           = 8'hff;
	localparam logic [7:0] COUNT_MIN           = 8'h00;
	localparam logic [7:0] COUNT_ONE           = 8'h01;
	// prescaler: 13 bits reach divide by 8192
	localparam int         PRESCALE_BITS       = 13;
	// tap index per clock select code: /8192 /2048 /512 /256 /128 /32 /8
	localparam logic [3:0] TAP_LOG2 [0:6] = '{4'hd, 4'hb, 4'h9, 4'h8, 4'h7, 4'h5, 4'h3};
endpackage

// >>> updown_reload_timer8_tb.sv
`timescale 1ns/10ps
`default_nettype none
module updown_reload_timer8_tb;
	import updown_reload_timer8_pkg::*;
	logic       clk_sys, rst, reg_wr, reg_rd, ev_lvl, dir_lvl, ev_pin, dir_pin, timer_irq;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	int         mismatches, checks_done;
	int         div [0:6] = '{8192, 2048, 512, 256, 128, 32, 8};

	pin_partner PM (.clk_sys(clk_sys), .ev_lvl(ev_lvl), .dir_lvl(dir_lvl),
		.event_count_pin(ev_pin), .dir_select_pin(dir_pin));
	updown_reload_timer8 DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_count_pin(ev_pin),
		.dir_select_pin(dir_pin), .timer_irq(timer_irq));

	task automatic report_and_stop();
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic ev(input logic lvl);
		@(posedge clk_sys);
		ev_lvl <= lvl;
		repeat (6) @(posedge clk_sys);
	endtask
	// mode, irq control, reload, dir pin, pulses, expected count and irq
	task automatic run(input logic [7:0] m, c, l, input logic dl, input int n, input logic [7:0] e, input logic q);
		dir_lvl <= dl;
		wr(ADDR_MODE_CONTROL, m);
		wr(ADDR_IRQ_CONTROL, c);
		wr(ADDR_COUNT_RELOAD, l);
		repeat (n) begin
			ev(1'b1);
			ev(1'b0);
		end
		rd_chk(ADDR_COUNT_RELOAD, e);
		chk({7'h0, timer_irq}, {7'h0, q});
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#8000000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		{rst, reg_wr, reg_rd, ev_lvl, dir_lvl} = 5'h10;
		reg_addr    = 2'h0;
		reg_wdata   = 8'h00;
		mismatches  = 0;
		checks_done = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk(ADDR_MODE_CONTROL, 8'h18);
		rd_chk(ADDR_COUNT_RELOAD, 8'h00);
		rd_chk(ADDR_IRQ_CONTROL, 8'h00);
		rd_chk(2'h3, 8'h00);
		wr(ADDR_MODE_CONTROL, 8'h00);
		rd_chk(ADDR_MODE_CONTROL, 8'h18);
		// each tap: exactly four steps in four periods
		for (int k = 0; k < 7; k++) begin
			wr(ADDR_MODE_CONTROL, 8'h18 | 8'(k));
			wr(ADDR_COUNT_RELOAD, 8'h40);
			repeat (4 * div[k] - 1) @(posedge clk_sys);
			rd_chk(ADDR_COUNT_RELOAD, 8'h44);
		end
		run(8'h07, 8'h06, 8'hfe, 1'b0, 2, 8'h00, 1'b1);
		rd_chk(ADDR_COUNT_RELOAD, 8'h00);
		rd_chk(ADDR_MODE_CONTROL, 8'h1f);
		wr(ADDR_IRQ_CONTROL, 8'h05);
		rd_chk(ADDR_IRQ_CONTROL, 8'h05);
		chk({7'h0, timer_irq}, 8'h00);
		run(8'h07, 8'h02, 8'h10, 1'b0, 0, 8'h10, 1'b0);
		ev(1'b1);
		rd_chk(ADDR_COUNT_RELOAD, 8'h10);
		ev(1'b0);
		rd_chk(ADDR_COUNT_RELOAD, 8'h11);
		run(8'h27, 8'h06, 8'h01, 1'b0, 2, 8'hff, 1'b1);
		run(8'h67, 8'h00, 8'h10, 1'b0, 1, 8'h11, 1'b0);
		run(8'h47, 8'h00, 8'h10, 1'b1, 1, 8'h0f, 1'b0);
		run(8'h87, 8'h06, 8'hfe, 1'b0, 2, 8'hfe, 1'b1);
		run(8'h87, 8'h06, 8'hff, 1'b0, 3, 8'hff, 1'b1);
		run(8'ha7, 8'h02, 8'h01, 1'b0, 2, 8'h01, 1'b1);
		rd_chk(ADDR_MODE_CONTROL, 8'hbf);
		report_and_stop();
	end
endmodule
`default_nettype wire
